/* logic/mir_pkg.sv */
// types shared by the memory/io range router
package mir_pkg;
  typedef logic [51:0] mir_addr_t;
  typedef logic [63:0] mir_reg_t;
  typedef logic [2:0]  mir_type_t;
  typedef enum logic [2:0] {
    MIR_SEL_BASE0, MIR_SEL_MASK0, MIR_SEL_BASE1, MIR_SEL_MASK1,
    MIR_SEL_LOW_TOP, MIR_SEL_HIGH_TOP, MIR_SEL_SYS_CONF, MIR_SEL_NONE
  } mir_sel_t;
endpackage

/* logic/mir_range_match.sv */
// one io range pair: hit test and steering
`timescale 1ns/1ns
`include "mir_regs.svh"
module mir_range_match (
  // range registers
  input  wire mir_pkg::mir_reg_t  base,
  input  wire mir_pkg::mir_reg_t  mask,
  // access
  input  wire mir_pkg::mir_addr_t addr,
  input  wire logic               is_write,
  // result
  output logic                    hit,
  output logic                    to_mem
);
  import mir_pkg::*;
  logic [`MIR_ADDR_HI-`MIR_ADDR_LO:0] m;
  assign m = mask[`MIR_ADDR_HI:`MIR_ADDR_LO];
  assign hit = mask[`MIR_BIT_VALID]
    && ((addr[`MIR_ADDR_HI:`MIR_ADDR_LO] & m)
        == (base[`MIR_ADDR_HI:`MIR_ADDR_LO] & m));
  assign to_mem = is_write ? base[`MIR_BIT_WR_MEM] : base[`MIR_BIT_RD_MEM];
endmodule

/* logic/mir_regs.svh */
// register offsets, field positions and reset values of the memory/io range router
// Function
// - two independent io ranges 0 and 1, each a base and mask register pair
// - base bit 3 set sends in-range writes to memory, clear to io
// - base bit 4 set sends in-range reads to memory, clear to io
// - base address in base bits 51..12, low twelve address bits zero
// - mask bit 11 enables its pair; clear means the pair is ignored
// - mask value in mask bits 51..12, low twelve bits zero
// - io range steering and memory type combine via the fixed-range encoding table
// - low top enabled: addresses below low top go to memory
// - low top up to just below 4 GB goes to io
// - high top enabled: 4 GB up to below high top goes to memory
// - high top up to highest address goes to io
// - top registers hold 8 MB aligned bits 51..23, other bits ignored
// - low top boundary active only while configuration bit 20 is one
// - high top boundary active only while configuration bit 21 is one
// - disabled top boundary leaves its memory region routed to io
// - top ranges combine steering and memory type via the same encoding table
// - defined base and mask fields read back as written
`ifndef MIR_REGS_SVH
`define MIR_REGS_SVH
`define MIR_IDX_BASE0    3'h0
`define MIR_IDX_MASK0    3'h1
`define MIR_IDX_BASE1    3'h2
`define MIR_IDX_MASK1    3'h3
`define MIR_IDX_LOW_TOP  3'h4
`define MIR_IDX_HIGH_TOP 3'h5
`define MIR_IDX_SYS_CONF 3'h6
`define MIR_BIT_WR_MEM   3
`define MIR_BIT_RD_MEM   4
`define MIR_BIT_VALID    11
`define MIR_ADDR_HI      51
`define MIR_ADDR_LO      12
`define MIR_TOP_LO       23
`define MIR_BIT_LOW_EN   20
`define MIR_BIT_HIGH_EN  21
`define MIR_RESET_VAL    64'h0000000000000000
`define MIR_BASE_RW      64'h000FFFFFFFFFF018
`define MIR_MASK_RW      64'h000FFFFFFFFFF800
`define MIR_TOP_RW       64'h000FFFFFFF800000
`define MIR_SYS_CONF_RW  64'h0000000000300000
`define MIR_FOUR_GB      52'h0000100000000
`endif

/* logic/mir_router.sv */
// memory/io range router: registers, top-of-memory and io range routing
`timescale 1ns/1ns
`include "mir_regs.svh"
module mir_router (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // register access port
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire mir_pkg::mir_sel_t  reg_sel,
  input  wire mir_pkg::mir_reg_t  reg_wdata,
  output logic [63:0]             reg_rdata,
  // core access
  input  wire logic               acc_valid,
  input  wire logic               acc_write,
  input  wire mir_pkg::mir_addr_t acc_addr,
  input  wire mir_pkg::mir_type_t acc_type,
  // routing result
  output logic                    route_valid,
  output logic                    route_to_mem,
  output logic                    route_to_io,
  output logic                    route_reserved
);
  import mir_pkg::*;

  mir_reg_t regs_r [2];
  mir_reg_t masks_r [2];
  mir_reg_t low_top_r;
  mir_reg_t high_top_r;
  mir_reg_t sys_conf_r;
  logic [1:0] hit;
  logic [1:0] hit_mem;
  logic       io_hit;
  logic       io_mem;
  logic       low_mem;
  logic       high_mem;
  logic       to_mem_nxt;
  logic       reserved_nxt;
  logic       rd_mem;
  logic       wr_mem;
  logic [63:0] rdata_nxt;

  // register writes; reserved bits stored as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_r[0]  <= `MIR_RESET_VAL;
      regs_r[1]  <= `MIR_RESET_VAL;
      masks_r[0] <= `MIR_RESET_VAL;
      masks_r[1] <= `MIR_RESET_VAL;
      low_top_r  <= `MIR_RESET_VAL;
      high_top_r <= `MIR_RESET_VAL;
      sys_conf_r <= `MIR_RESET_VAL;
    end else if (reg_wr) begin
      unique case (reg_sel)
        MIR_SEL_BASE0:    regs_r[0]  <= reg_wdata & `MIR_BASE_RW;
        MIR_SEL_MASK0:    masks_r[0] <= reg_wdata & `MIR_MASK_RW;
        MIR_SEL_BASE1:    regs_r[1]  <= reg_wdata & `MIR_BASE_RW;
        MIR_SEL_MASK1:    masks_r[1] <= reg_wdata & `MIR_MASK_RW;
        MIR_SEL_LOW_TOP:  low_top_r  <= reg_wdata & `MIR_TOP_RW;
        MIR_SEL_HIGH_TOP: high_top_r <= reg_wdata & `MIR_TOP_RW;
        MIR_SEL_SYS_CONF: sys_conf_r <= reg_wdata & `MIR_SYS_CONF_RW;
        MIR_SEL_NONE: ;
      endcase
    end
  end

  // readback, registered so the output comes from a flip-flop
  always_comb begin
    unique case (reg_sel)
      MIR_SEL_BASE0:    rdata_nxt = regs_r[0];
      MIR_SEL_MASK0:    rdata_nxt = masks_r[0];
      MIR_SEL_BASE1:    rdata_nxt = regs_r[1];
      MIR_SEL_MASK1:    rdata_nxt = masks_r[1];
      MIR_SEL_LOW_TOP:  rdata_nxt = low_top_r;
      MIR_SEL_HIGH_TOP: rdata_nxt = high_top_r;
      MIR_SEL_SYS_CONF: rdata_nxt = sys_conf_r;
      MIR_SEL_NONE:     rdata_nxt = 64'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) reg_rdata <= 64'h0;
    else if (reg_rd) reg_rdata <= rdata_nxt;
  end

  // io range pairs
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rng
      mir_range_match u_match (
        .base     (regs_r[g]),
        .mask     (masks_r[g]),
        .addr     (acc_addr),
        .is_write (acc_write),
        .hit      (hit[g]),
        .to_mem   (hit_mem[g])
      );
    end
  endgenerate

  // overlap is software's problem; range 0 wins as a fixed choice
  assign io_hit = |hit;
  assign io_mem = hit[0] ? hit_mem[0] : hit_mem[1];

  // top-of-memory; only bits 51..23 compared
  assign low_mem = sys_conf_r[`MIR_BIT_LOW_EN]
    && (acc_addr < `MIR_FOUR_GB)
    && (acc_addr[`MIR_ADDR_HI:`MIR_TOP_LO]
        < low_top_r[`MIR_ADDR_HI:`MIR_TOP_LO]);
  assign high_mem = sys_conf_r[`MIR_BIT_HIGH_EN]
    && (acc_addr >= `MIR_FOUR_GB)
    && (acc_addr[`MIR_ADDR_HI:`MIR_TOP_LO]
        < high_top_r[`MIR_ADDR_HI:`MIR_TOP_LO]);

  // io range overrides top-of-memory; disabled tops fall to io
  assign to_mem_nxt = io_hit ? io_mem : (low_mem | high_mem);

  // steering pair presented to the type table
  assign rd_mem = io_hit ? (hit[0] ? regs_r[0][`MIR_BIT_RD_MEM] : regs_r[1][`MIR_BIT_RD_MEM])
                         : (low_mem | high_mem);
  assign wr_mem = io_hit ? (hit[0] ? regs_r[0][`MIR_BIT_WR_MEM] : regs_r[1][`MIR_BIT_WR_MEM])
                         : (low_mem | high_mem);

  mir_type_combine u_comb (
    .mtype    (acc_type),
    .rd_mem   (rd_mem),
    .wr_mem   (wr_mem),
    .reserved (reserved_nxt)
  );

  // registered routing result, one cycle after the access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      route_valid    <= 1'b0;
      route_to_mem   <= 1'b0;
      route_to_io    <= 1'b0;
      route_reserved <= 1'b0;
    end else begin
      route_valid    <= acc_valid;
      route_to_mem   <= acc_valid & to_mem_nxt;
      route_to_io    <= acc_valid & ~to_mem_nxt;
      route_reserved <= acc_valid & reserved_nxt;
    end
  end

  // checks
  a_route_excl: assert property (@(posedge core_clk) disable iff (rst)
    route_valid |-> (route_to_mem ^ route_to_io))
    else $error("route not exclusive");
  a_disabled_io: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && sys_conf_r[21:20] == 2'h0) |=> route_to_io)
    else $error("disabled tops not io");
  a_range_wr: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && acc_write && hit[0]) |=> route_to_mem == $past(regs_r[0][3]))
    else $error("write steering wrong");
  a_range_rd: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !acc_write && hit[0]) |=> route_to_mem == $past(regs_r[0][4]))
    else $error("read steering wrong");
  a_invalid_pair: assert property (@(posedge core_clk) disable iff (rst)
    (!masks_r[0][11]) |-> !hit[0])
    else $error("disabled pair hit");
  a_low_top_mem: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && sys_conf_r[20] && acc_addr[51:32] == 20'h0
     && acc_addr[31:23] < low_top_r[31:23] && low_top_r[51:32] == 20'h0) |=> route_to_mem)
    else $error("low memory not routed to memory");
  a_below_4g_io: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && acc_addr[51:32] == 20'h0
     && acc_addr[51:23] >= low_top_r[51:23]) |=> route_to_io)
    else $error("above low top not io");
  a_high_top_io: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && acc_addr[51:32] != 20'h0
     && acc_addr[51:23] >= high_top_r[51:23]) |=> route_to_io)
    else $error("above high top not io");
  a_high_en: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && !sys_conf_r[21] && acc_addr[51:32] != 20'h0) |=> route_to_io)
    else $error("high top used while disabled");
  a_readback: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_BASE0) ##1 !reg_wr ##1 (reg_rd && reg_sel == MIR_SEL_BASE0)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_BASE_RW))
    else $error("base readback wrong");
  c_io_hit:   cover property (@(posedge core_clk) acc_valid && io_hit);
  c_low_mem:  cover property (@(posedge core_clk) acc_valid && low_mem);
  c_high_mem: cover property (@(posedge core_clk) acc_valid && high_mem);
  c_reserved: cover property (@(posedge core_clk) route_reserved);
  c_range1:   cover property (@(posedge core_clk) acc_valid && !hit[0] && hit[1]);

  // readback of every register, write then read with one idle cycle between
  a_readback_mask0: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_MASK0) ##1 !reg_wr ##1 (reg_rd && reg_sel == MIR_SEL_MASK0)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_MASK_RW))
    else $error("mask 0 readback wrong");

  a_readback_base1: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_BASE1) ##1 !reg_wr ##1 (reg_rd && reg_sel == MIR_SEL_BASE1)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_BASE_RW))
    else $error("base 1 readback wrong");

  a_readback_mask1: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_MASK1) ##1 !reg_wr ##1 (reg_rd && reg_sel == MIR_SEL_MASK1)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_MASK_RW))
    else $error("mask 1 readback wrong");

  a_readback_low: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_LOW_TOP) ##1 !reg_wr
    ##1 (reg_rd && reg_sel == MIR_SEL_LOW_TOP)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_TOP_RW))
    else $error("low top readback wrong");

  a_readback_high: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_HIGH_TOP) ##1 !reg_wr
    ##1 (reg_rd && reg_sel == MIR_SEL_HIGH_TOP)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_TOP_RW))
    else $error("high top readback wrong");

  a_readback_conf: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_sel == MIR_SEL_SYS_CONF) ##1 !reg_wr
    ##1 (reg_rd && reg_sel == MIR_SEL_SYS_CONF)
    |=> reg_rdata == ($past(reg_wdata, 3) & `MIR_SYS_CONF_RW))
    else $error("configuration readback wrong");

  a_none_zero: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_sel == MIR_SEL_NONE) |=> reg_rdata == 64'h0)
    else $error("unused select not zero");

  // read data stands until the next read strobe
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  a_reset_clear: assert property (@(posedge core_clk)
    $past(rst) |-> (!route_valid && reg_rdata == 64'h0))
    else $error("outputs not cleared by reset");

  // routing result framing
  a_route_idle: assert property (@(posedge core_clk) disable iff (rst)
    !route_valid |-> (!route_to_mem && !route_to_io && !route_reserved))
    else $error("route flags outside valid");

  a_route_follows: assert property (@(posedge core_clk) disable iff (rst)
    acc_valid |=> route_valid)
    else $error("access without route");

  a_route_only: assert property (@(posedge core_clk) disable iff (rst)
    !acc_valid |=> !route_valid)
    else $error("route without access");

  // range 1 steering, seen only when range 0 misses
  a_range1_wr: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && acc_write && !hit[0] && hit[1])
    |=> route_to_mem == $past(regs_r[1][3]))
    else $error("range 1 write steering wrong");

  a_range1_rd: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !acc_write && !hit[0] && hit[1])
    |=> route_to_mem == $past(regs_r[1][4]))
    else $error("range 1 read steering wrong");

  a_invalid_pair1: assert property (@(posedge core_clk) disable iff (rst)
    (!masks_r[1][11]) |-> !hit[1])
    else $error("disabled pair 1 hit");

  // an address equal to the base always falls inside an enabled range
  a_base_hit0: assert property (@(posedge core_clk) disable iff (rst)
    (masks_r[0][11] && acc_addr[51:12] == regs_r[0][51:12]) |-> hit[0])
    else $error("base address missed range 0");

  a_base_hit1: assert property (@(posedge core_clk) disable iff (rst)
    (masks_r[1][11] && acc_addr[51:12] == regs_r[1][51:12]) |-> hit[1])
    else $error("base address missed range 1");

  // top-of-memory regions
  a_high_top_mem: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && sys_conf_r[21] && acc_addr[51:32] != 20'h0
     && acc_addr[51:23] < high_top_r[51:23]) |=> route_to_mem)
    else $error("high memory not routed to memory");

  a_low_en: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && !sys_conf_r[20] && acc_addr[51:32] == 20'h0) |=> route_to_io)
    else $error("low top used while disabled");

  // ignored and reserved bits never stored
  a_top_ignored: assert property (@(posedge core_clk) disable iff (rst)
    ((low_top_r & ~`MIR_TOP_RW) == 64'h0) && ((high_top_r & ~`MIR_TOP_RW) == 64'h0))
    else $error("ignored top bits stored");

  // steering/type table cells
  a_io_wb_resv: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && !(low_mem | high_mem) && acc_type == 3'h6) |=> route_reserved)
    else $error("io write-back not flagged");

  a_mem_wp_resv: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && !io_hit && (low_mem | high_mem) && acc_type == 3'h5) |=> route_reserved)
    else $error("memory write-protect not flagged");

  a_uc_allowed: assert property (@(posedge core_clk) disable iff (rst)
    (acc_valid && acc_type == 3'h0) |=> !route_reserved)
    else $error("uncached access flagged");
endmodule

/* logic/mir_type_combine.sv */
// combines memory/io steering with memory type by the allowed-combination table
`timescale 1ns/1ns
`include "mir_regs.svh"
module mir_type_combine (
  // inputs
  input  wire mir_pkg::mir_type_t mtype,
  input  wire logic               rd_mem,
  input  wire logic               wr_mem,
  // outputs
  output logic                    reserved
);
  import mir_pkg::*;
  // reserved combos give undefined behaviour; flagged only, routing unchanged
  always_comb begin
    unique case ({rd_mem, wr_mem})
      2'h0: reserved = !(mtype inside {3'h0, 3'h1, 3'h4, 3'h5});
      2'h1: reserved = !(mtype inside {3'h0, 3'h1});
      2'h2: reserved = !(mtype inside {3'h0, 3'h5});
      default: reserved = !(mtype inside {3'h0, 3'h1, 3'h4, 3'h6});
    endcase
  end
endmodule

/* sim/mir_core_model.sv */
// core model issuing one physical access per call
`timescale 1ns/1ns
module mir_core_model (
  // clock
  input  wire logic          core_clk,
  // access toward the router
  output logic               acc_valid,
  output logic               acc_write,
  output mir_pkg::mir_addr_t acc_addr,
  output mir_pkg::mir_type_t acc_type
);
  import mir_pkg::*;
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr  = '0;
    acc_type  = '0;
  end
  // released lines flip so a stale address never passes for a live one
  task automatic issue(input logic wr, input mir_addr_t a, input mir_type_t t);
    @(posedge core_clk);
    #1;
    acc_valid = 1'b1;
    acc_write = wr;
    acc_addr  = a;
    acc_type  = t;
    @(posedge core_clk);
    #1;
    acc_valid = 1'b0;
    acc_write = ~wr;
    acc_addr  = ~a;
    acc_type  = ~t;
  endtask
endmodule

/* sim/test_memory_io_range_router.sv */
// self-checking bench for the memory/io range router
`timescale 1ns/1ns
`include "mir_regs.svh"
module test_memory_io_range_router;
  import mir_pkg::*;
  localparam mir_reg_t RW [8] = '{`MIR_BASE_RW, `MIR_MASK_RW, `MIR_BASE_RW, `MIR_MASK_RW,
                                 `MIR_TOP_RW, `MIR_TOP_RW, `MIR_SYS_CONF_RW, 64'h0};
  localparam mir_type_t TY [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  mir_sel_t    reg_sel = MIR_SEL_NONE;
  mir_reg_t    reg_wdata = '0;
  logic [63:0] reg_rdata;
  logic        acc_valid, acc_write, route_valid, route_to_mem, route_to_io, route_reserved;
  mir_addr_t   acc_addr;
  mir_type_t   acc_type;
  mir_reg_t    sh [8];
  mir_addr_t   pt [5];
  int          n_fail = 0;
  int          tests_run = 0;
  always #10 core_clk = ~core_clk;
  mir_core_model mir_core_model_i (.core_clk(core_clk), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_type(acc_type));
  mir_router mir_router_i (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_type(acc_type),
    .route_valid(route_valid), .route_to_mem(route_to_mem), .route_to_io(route_to_io),
    .route_reserved(route_reserved));
  function automatic mir_reg_t rnd64();
    return {$urandom, $urandom};
  endfunction
  function automatic logic [3:0] expect_route(input logic wr, input mir_addr_t a,
                                              input mir_type_t t);
    logic h0, h1, rm, wm, m, rs;
    h0 = sh[1][11] && ((a[51:12] & sh[1][51:12]) == (sh[0][51:12] & sh[1][51:12]));
    h1 = sh[3][11] && ((a[51:12] & sh[3][51:12]) == (sh[2][51:12] & sh[3][51:12]));
    // overlapping ranges are undefined; range 0 taken, as the design does
    if (h0 || h1) begin
      rm = h0 ? sh[0][4] : sh[2][4];
      wm = h0 ? sh[0][3] : sh[2][3];
    end else begin
      rm = (a < `MIR_FOUR_GB) ? sh[6][20] && a < sh[4][51:0] : sh[6][21] && a < sh[5][51:0];
      wm = rm;
    end
    m = wr ? wm : rm;
    // reserved cells of the steering/type table, only flagged
    case ({rm, wm})
      2'b00: rs = t == 3'h6;
      2'b01: rs = t == 3'h4 || t == 3'h5 || t == 3'h6;
      2'b10: rs = t == 3'h1 || t == 3'h4 || t == 3'h6;
      default: rs = t == 3'h5;
    endcase
    return {1'b1, m, ~m, rs};
  endfunction
  task automatic check64(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_route(input logic [3:0] exp);
    tests_run++;
    if ({route_valid, route_to_mem, route_to_io, route_reserved} !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: route %b expected %b", $time,
               {route_valid, route_to_mem, route_to_io, route_reserved}, exp);
    end
  endtask
  task automatic access(input logic wr, input mir_addr_t a, input mir_type_t t);
    mir_core_model_i.issue(wr, a, t);
    check_route(expect_route(wr, a, t));
  endtask
  task automatic reg_write(input mir_sel_t s, input mir_reg_t d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    sh[s] = d & RW[s];
  endtask
  task automatic reg_check(input mir_sel_t s);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_sel = s;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    check64(reg_rdata, sh[s]);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    void'($urandom(32'h30c1));
    for (int i = 0; i < 8; i++) sh[i] = '0;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    for (int s = 0; s < 8; s++) reg_check(mir_sel_t'(s));
    // everything disabled: an all-zero pair would match all if valid were ignored
    for (int i = 0; i < 10; i++) access(i[0], mir_addr_t'(rnd64()), TY[i % 5]);
    for (int s = 0; s < 8; s++) begin
      reg_write(mir_sel_t'(s), '1);
      reg_check(mir_sel_t'(s));
    end
    for (int r = 0; r < 12; r++) begin
      for (int k = 0; k < 4; k += 2) begin
        reg_write(mir_sel_t'(k), rnd64() & `MIR_BASE_RW);
        reg_write(mir_sel_t'(k + 1), (~64'h0 << (12 + $urandom_range(20))) & `MIR_MASK_RW
                  | (rnd64() & 64'h800));
      end
      reg_write(MIR_SEL_LOW_TOP, rnd64() & 64'hFFFFFFFF & `MIR_TOP_RW);
      reg_write(MIR_SEL_HIGH_TOP, rnd64() & `MIR_TOP_RW);
      reg_write(MIR_SEL_SYS_CONF, rnd64());
      reg_check(mir_sel_t'(r % 8));
      pt = '{mir_addr_t'(sh[0]), mir_addr_t'(sh[2]), mir_addr_t'(sh[4]), `MIR_FOUR_GB,
             mir_addr_t'(sh[5])};
      // exact boundaries and one below, both directions
      for (int j = 0; j < 20; j++) begin
        access(j[1], pt[j / 4] - mir_addr_t'(j % 2), TY[j % 5]);
      end
      for (int j = 0; j < 20; j++) begin
        access(1'($urandom_range(1)), pt[$urandom_range(4)] + mir_addr_t'($urandom_range(8))
               - 52'h4, TY[$urandom_range(4)]);
      end
    end
    stop_test;
  end
endmodule
